// ==== rtl/utility_bus_page_decoder.sv ====
// 64-bit subordinate port that routes beats to per-core register set pages
// assumes register sets answer each request with one done pulse, within 300 cycles
module utility_bus_page_decoder
  import ubus_page_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              sys_rst_in,
  input  wire axi_addr_t         aw_in,
  output logic                   aw_ready_out,
  input  wire axi_w_t            w_in,
  output logic                   w_ready_out,
  output axi_b_t                 b_out,
  input  wire logic              b_ready_in,
  input  wire axi_addr_t         ar_in,
  output logic                   ar_ready_out,
  output axi_r_t                 r_out,
  input  wire logic              r_ready_in,
  output reg_req_t               req_out,
  input  wire logic [DATA_W-1:0] req_rdata_in,
  input  wire logic              req_done_in
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    bus_state_t        st;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        prot;
    logic [ID_W-1:0]   id;
    logic [7:0]        len;
    logic              last;
    logic              ar_ready;
    logic              aw_ready;
    logic              w_ready;
    axi_b_t            b;
    axi_r_t            r;
    reg_req_t          req;
  } core_state_t;

  core_state_t s;
  core_state_t next_s;
  page_sel_t   sel;
  logic        allowed;
  logic        beat_done;

  // decode always looks at the beat currently held
  page_decoder u_decode (
    .addr_in     (s.addr),
    .prot_in     (s.prot),
    .sel_out     (sel),
    .allowed_out (allowed)
  );

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  // one transaction at a time keeps ordering trivial; throughput is not a goal here
  always_comb begin
    next_s           = s;
    next_s.req.valid = 1'b0;
    beat_done        = 1'b0;
    case (s.st)
      ST_IDLE: begin
        if (ar_in.valid && s.ar_ready) begin
          next_s.addr     = ar_in.addr;
          next_s.prot     = ar_in.prot;
          next_s.id       = ar_in.id;
          next_s.len      = ar_in.len;
          next_s.ar_ready = 1'b0;
          next_s.aw_ready = 1'b0;
          next_s.st       = ST_RD_ISSUE;
        end else if (aw_in.valid && s.aw_ready) begin
          next_s.addr     = aw_in.addr;
          next_s.prot     = aw_in.prot;
          next_s.id       = aw_in.id;
          next_s.len      = aw_in.len;
          next_s.ar_ready = 1'b0;
          next_s.aw_ready = 1'b0;
          next_s.w_ready  = 1'b1;
          next_s.st       = ST_WR_DATA;
        end else begin
          // only one address channel is open at a time, so both can never be taken together
          next_s.ar_ready = ~s.ar_ready;
          next_s.aw_ready = s.ar_ready;
        end
      end
      ST_RD_ISSUE: begin
        next_s.r.id   = s.id;
        next_s.r.resp = RESP_OKAY;
        next_s.r.last = (s.len == '0);
        if (allowed) begin
          next_s.req.valid  = 1'b1;
          next_s.req.write  = 1'b0;
          next_s.req.kind   = sel.kind;
          next_s.req.core   = sel.core;
          next_s.req.offset = sel.offset;
          next_s.st         = ST_RD_WAIT;
        end else begin
          next_s.r.valid = 1'b1;
          next_s.r.data  = '0;
          next_s.st      = ST_RD_RESP;
        end
      end
      ST_RD_WAIT: begin
        if (req_done_in) begin
          next_s.r.valid = 1'b1;
          next_s.r.data  = req_rdata_in;
          next_s.st      = ST_RD_RESP;
        end
      end
      ST_RD_RESP: begin
        if (r_ready_in) begin
          next_s.r.valid = 1'b0;
          if (s.r.last) begin
            next_s.aw_ready = 1'b1;  // writes get the next turn
            next_s.st       = ST_IDLE;
          end else begin
            next_s.addr = next_beat(s.addr);
            next_s.len  = s.len - LEN_ONE;
            next_s.st   = ST_RD_ISSUE;
          end
        end
      end
      ST_WR_DATA: begin
        if (w_in.valid) begin
          next_s.req.wdata = w_in.data;
          next_s.req.wstrb = w_in.strb;
          next_s.last      = w_in.last;
          next_s.w_ready   = 1'b0;
          next_s.st        = ST_WR_ISSUE;
        end
      end
      ST_WR_ISSUE: begin
        if (allowed) begin
          next_s.req.valid  = 1'b1;
          next_s.req.write  = 1'b1;
          next_s.req.kind   = sel.kind;
          next_s.req.core   = sel.core;
          next_s.req.offset = sel.offset;
          next_s.st         = ST_WR_WAIT;
        end else begin
          beat_done = 1'b1;
        end
      end
      ST_WR_WAIT: beat_done = req_done_in;
      ST_WR_RESP: begin
        if (b_ready_in) begin
          next_s.b.valid  = 1'b0;
          next_s.ar_ready = 1'b1;  // reads get the next turn
          next_s.st       = ST_IDLE;
        end
      end
      default: next_s = '0;
    endcase
    // common end of a write beat
    if (beat_done) begin
      if (s.last) begin
        next_s.b.valid = 1'b1;
        next_s.b.id    = s.id;
        next_s.b.resp  = RESP_OKAY;
        next_s.st      = ST_WR_RESP;
      end else begin
        next_s.addr    = next_beat(s.addr);
        next_s.w_ready = 1'b1;
        next_s.st      = ST_WR_DATA;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  // single 64-bit port
  assign aw_ready_out = s.aw_ready;
  assign w_ready_out  = s.w_ready;
  assign ar_ready_out = s.ar_ready;
  assign b_out        = s.b;
  assign r_out        = s.r;
  assign req_out      = s.req;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  logic ar_take;
  logic err_kind;
  assign ar_take  = ar_in.valid && s.ar_ready && (s.st == ST_IDLE);
  assign err_kind = (req_out.kind == PK_CORE_ERR) || (req_out.kind == PK_COMPLEX_ERR);

  single_beat_read_a: assert property (ar_take && ar_in.len == '0 |-> ##[2:300] (r_out.valid && r_out.last))
    else $error("single beat read did not finish");
  page_of_beat_a: assert property (req_out.valid |-> req_out.offset == s.addr[15:0] &&
                                   req_out.core == s.addr[23:20] && s.addr[31:24] == '0)
    else $error("request left its page");
  activity_route_a: assert property (req_out.valid && s.addr[19:16] == PAGE_ACTIVITY
                                     |-> req_out.kind == PK_ACTIVITY)
    else $error("activity page misrouted");
  error_route_a: assert property (req_out.valid && s.addr[19:16] == PAGE_CORE_ERR
                                  |-> req_out.kind == PK_CORE_ERR)
    else $error("core error page misrouted");
  power_route_a: assert property (req_out.valid && s.addr[19:16] == PAGE_POWER
                                  |-> req_out.kind == PK_POWER && req_out.core < CORE_COUNT)
    else $error("power page misrouted");
  complex_first_a: assert property (req_out.valid && req_out.kind == PK_COMPLEX_ERR
                                    |-> req_out.core == FIRST_CORE)
    else $error("complex page decoded for another core");
  reserved_zero_a: assert property (s.st == ST_RD_ISSUE && s.addr[19:16] >= PAGE_RSVD_FIRST
                                    |=> r_out.valid && r_out.data == '0 && !req_out.valid)
    else $error("reserved page not read as zero");
  secure_gate_a: assert property (req_out.valid && s.prot[1] |-> req_out.kind == PK_ACTIVITY)
    else $error("non-secure access reached a secure page");
  err_layout_a: assert property (req_out.valid && err_kind |-> req_out.offset < REC_END ||
                                 (req_out.offset >= PFG_FIRST && req_out.offset <= PFG_END) ||
                                 req_out.offset >= ID_FIRST)
    else $error("error page offset outside its layout");
  blocked_write_a: assert property (s.st == ST_WR_ISSUE && !allowed
                                    |=> !req_out.valid && (b_out.valid || w_ready_out))
    else $error("blocked write stalled or leaked");
  okay_resp_a: assert property ((b_out.valid |-> b_out.resp == RESP_OKAY) and
                                (r_out.valid |-> r_out.resp == RESP_OKAY))
    else $error("response not okay");

  read_done_c: cover property (r_out.valid && r_ready_in && r_out.last);
  write_done_c: cover property (b_out.valid && b_ready_in);
  nonsecure_block_c: cover property (s.st == ST_WR_ISSUE && sel.secure_only && s.prot[1]);
  complex_hit_c: cover property (req_out.valid && req_out.kind == PK_COMPLEX_ERR);

endmodule : utility_bus_page_decoder

// ==== rtl/ubus_page_pkg.sv ====
// shared types and constants for the utility bus page decoder
// assumes one clock and a synchronous reset; the port sees local addresses only
package ubus_page_pkg;

  // ----------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int STRB_W = 8;
  localparam int ID_W   = 4;

  // ----------------------------------------------------------------
  // address fields of the local map
  // ----------------------------------------------------------------
  localparam int OFFSET_LSB = 0;   // byte offset inside a 64KB page
  localparam int PAGE_LSB   = 16;  // page digit
  localparam int CORE_LSB   = 20;  // core instance digit
  localparam int UPPER_LSB  = 24;  // bits above the local map, must be zero

  localparam logic [3:0] CORE_COUNT       = 4'h4;  // cores behind this port
  localparam logic [3:0] FIRST_CORE       = 4'h0;  // first core of the complex
  localparam logic [3:0] PAGE_ACTIVITY    = 4'h9;
  localparam logic [3:0] PAGE_CORE_ERR    = 4'ha;
  localparam logic [3:0] PAGE_POWER       = 4'hb;
  localparam logic [3:0] PAGE_COMPLEX_ERR = 4'hc;
  localparam logic [3:0] PAGE_RSVD_FIRST  = 4'hd;

  // ----------------------------------------------------------------
  // layout inside an error record page
  // ----------------------------------------------------------------
  localparam logic [15:0] REC_END   = 16'h0040;  // records live below this
  localparam logic [15:0] PFG_FIRST = 16'h0800;
  localparam logic [15:0] PFG_LAST  = 16'h0810;  // last pseudo-fault word base
  localparam logic [15:0] PFG_END   = 16'h0817;  // last byte of that word
  localparam logic [15:0] ID_FIRST  = 16'h0e00;
  localparam logic [15:0] ID_LAST   = 16'h0fff;

  localparam logic [31:0] BEAT_STEP = 32'h0000_0008;  // one 64-bit beat
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [7:0]  LEN_ONE   = 8'h01;

  typedef enum logic [1:0] {PK_ACTIVITY, PK_CORE_ERR, PK_POWER, PK_COMPLEX_ERR} page_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_ISSUE, ST_RD_WAIT, ST_RD_RESP, ST_WR_DATA, ST_WR_ISSUE, ST_WR_WAIT, ST_WR_RESP
  } bus_state_t;

  typedef struct packed {
    logic              hit;          // documented page and offset
    logic              secure_only;  // page refuses non-secure access
    page_kind_t        kind;
    logic [3:0]        core;
    logic [15:0]       offset;
  } page_sel_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    page_kind_t        kind;
    logic [3:0]        core;
    logic [15:0]       offset;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
  } reg_req_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        prot;
    logic [ID_W-1:0]   id;
    logic [7:0]        len;
  } axi_addr_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
    logic              last;
  } axi_w_t;

  typedef struct packed {
    logic              valid;
    logic [ID_W-1:0]   id;
    logic [1:0]        resp;
  } axi_b_t;

  typedef struct packed {
    logic              valid;
    logic [ID_W-1:0]   id;
    logic [DATA_W-1:0] data;
    logic [1:0]        resp;
    logic              last;
  } axi_r_t;

  // address of the following beat of an incrementing burst
  function automatic logic [ADDR_W-1:0] next_beat(input logic [ADDR_W-1:0] addr);
    next_beat = addr + BEAT_STEP;
  endfunction : next_beat

endpackage : ubus_page_pkg

// ==== rtl/page_decoder.sv ====
// combinational page decode of one local utility bus address
// assumes the address has already had the system base removed
module page_decoder
  import ubus_page_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [2:0]        prot_in,
  output page_sel_t              sel_out,
  output logic                   allowed_out
);

  // ----------------------------------------------------------------
  // offset check for error record pages
  // ----------------------------------------------------------------
  function automatic logic err_offset_ok(input logic [15:0] off);
    err_offset_ok = (off < REC_END) || (off >= PFG_FIRST && off <= PFG_END) ||
                    (off >= ID_FIRST && off <= ID_LAST);
  endfunction : err_offset_ok

  logic [3:0] page;
  logic       upper_ok;
  logic       core_ok;

  // split the address into core digit, page digit and offset
  always_comb begin
    page                = addr_in[PAGE_LSB +: 4];
    upper_ok            = (addr_in[ADDR_W-1:UPPER_LSB] == '0);
    core_ok             = (addr_in[CORE_LSB +: 4] < CORE_COUNT);
    sel_out.core        = addr_in[CORE_LSB +: 4];
    sel_out.offset      = addr_in[OFFSET_LSB +: 16];
    sel_out.hit         = 1'b0;
    sel_out.secure_only = 1'b1;
    sel_out.kind        = PK_ACTIVITY;
    case (page)
      PAGE_ACTIVITY: begin
        sel_out.hit         = 1'b1;
        sel_out.secure_only = 1'b0;
      end
      PAGE_CORE_ERR: begin
        sel_out.kind = PK_CORE_ERR;
        sel_out.hit  = err_offset_ok(addr_in[15:0]);
      end
      PAGE_POWER: begin
        sel_out.kind = PK_POWER;
        sel_out.hit  = 1'b1;
      end
      PAGE_COMPLEX_ERR: begin
        sel_out.kind = PK_COMPLEX_ERR;
        sel_out.hit  = (addr_in[CORE_LSB +: 4] == FIRST_CORE) && err_offset_ok(addr_in[15:0]);
      end
      default: sel_out.hit = 1'b0;
    endcase
    allowed_out = sel_out.hit && upper_ok && core_ok && !(sel_out.secure_only && prot_in[1]);
  end

endmodule : page_decoder

// ==== bench/reg_set_model.sv ====
// register set stand-in on the far side of the page decoder
// assumes one request outstanding; delay_in of at least one cycle
module reg_set_model
  import ubus_page_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              sys_rst_in,
  input  wire reg_req_t          req_in,
  input  wire logic [7:0]        delay_in,
  output logic [DATA_W-1:0]      rdata_out,
  output logic                   done_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0]        cnt;
  logic [DATA_W-1:0] word;

  always_ff @(posedge clk_sys_in) begin
    done_out <= 1'b0;
    if (sys_rst_in) begin
      cnt  <= 8'h00;
      word <= '0;
    end else if (req_in.valid) begin
      cnt <= delay_in;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) begin
        done_out <= 1'b1;
        word     <= {42'h155, req_in.kind, req_in.core, req_in.offset};
      end
    end
  end

  // outside the done cycle the data lines show junk, so stale reads get caught
  assign rdata_out = done_out ? word : ~word;
endmodule : reg_set_model

// ==== bench/utility_bus_page_decoder_tb.sv ====
// self-checking bench for the utility bus page decoder
// assumes the manager sees local addresses, no system base added; one read in t_err_layout sets bits above the local map
module utility_bus_page_decoder_tb
  import ubus_page_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys_in, sys_rst_in, aw_ready_out, w_ready_out, b_ready_in;
  logic ar_ready_out, r_ready_in, req_done_in;
  axi_addr_t aw_in, ar_in;
  axi_w_t    w_in;
  axi_b_t    b_out;
  axi_r_t    r_out;
  reg_req_t  req_out, lreq;
  logic [DATA_W-1:0] req_rdata_in;
  logic [7:0] delay;
  int nreq = 0;
  int error_cnt = 0;
  int tests_run = 0;

  utility_bus_page_decoder dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .aw_in(aw_in),
    .aw_ready_out(aw_ready_out), .w_in(w_in), .w_ready_out(w_ready_out), .b_out(b_out),
    .b_ready_in(b_ready_in), .ar_in(ar_in), .ar_ready_out(ar_ready_out), .r_out(r_out),
    .r_ready_in(r_ready_in), .req_out(req_out), .req_rdata_in(req_rdata_in), .req_done_in(req_done_in));
  reg_set_model model_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .req_in(req_out),
    .delay_in(delay), .rdata_out(req_rdata_in), .done_out(req_done_in));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // requests are counted at the falling edge, where they are settled
  always @(negedge clk_sys_in) if (sys_rst_in === 1'b0 && req_out.valid === 1'b1) begin
    nreq++;
    lreq = req_out;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one transfer; the address is local except for the upper-bits read in t_err_layout
  task automatic access(input logic wr, input logic [31:0] addr, input logic [2:0] prot,
                        input logic [7:0] len, input logic hit);
    int n;
    int n0;
    logic [15:0] off;
    logic [1:0] k;
    axi_r_t got;
    n0 = nreq;
    k = 2'(addr[19:16] - 4'h9);
    if (wr) begin
      aw_in <= '{1'b1, addr, prot, 4'h6, 8'h00};
      w_in  <= '{1'b1, {32'h5a5a_0000, addr}, 8'h0f, 1'b1};
      @(negedge clk_sys_in);
      for (n = 0; n < 400 && aw_ready_out !== 1'b1; n++) @(negedge clk_sys_in);
      @(posedge clk_sys_in) aw_in.valid <= 1'b0;
      @(negedge clk_sys_in);
      for (n = 0; n < 400 && w_ready_out !== 1'b1; n++) @(negedge clk_sys_in);
      @(posedge clk_sys_in) w_in.valid <= 1'b0;
      @(negedge clk_sys_in);
      for (n = 0; n < 400 && b_out.valid !== 1'b1; n++) @(negedge clk_sys_in);
      check({b_out.id, b_out.resp}, {4'h6, RESP_OKAY});
      @(posedge clk_sys_in) b_ready_in <= 1'b1;
      @(posedge clk_sys_in) b_ready_in <= 1'b0;
      if (hit) check({lreq.write, lreq.kind, lreq.core, lreq.offset, lreq.wstrb},
                     {1'b1, k, addr[23:20], addr[15:0], 8'h0f});
      if (hit) check(lreq.wdata, {32'h5a5a_0000, addr});
      check(nreq - n0, hit);
    end else begin
      ar_in <= '{1'b1, addr, prot, 4'h5, len};
      @(negedge clk_sys_in);
      for (n = 0; n < 400 && ar_ready_out !== 1'b1; n++) @(negedge clk_sys_in);
      @(posedge clk_sys_in) ar_in.valid <= 1'b0;
      for (int b = 0; b <= len; b++) begin
        off = addr[15:0] + 16'(8 * b);
        @(negedge clk_sys_in);
        for (n = 0; n < 400 && r_out.valid !== 1'b1; n++) @(negedge clk_sys_in);
        got = r_out;
        @(posedge clk_sys_in) r_ready_in <= 1'b1;
        @(negedge clk_sys_in) check(r_out.valid, 1'b1);
        @(posedge clk_sys_in) r_ready_in <= 1'b0;
        check(got.data, hit ? {42'h155, k, addr[23:20], off} : 64'h0);
        check({got.id, got.resp, got.last}, {4'h5, RESP_OKAY, b == len});
        if (hit) check({lreq.write, lreq.kind, lreq.core, lreq.offset}, {1'b0, k, addr[23:20], off});
      end
      check(nreq - n0, hit ? len + 1 : 0);
    end
  endtask : access

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // core digits 0 to 4 with page digits 9 to f
  task automatic t_page_map;
    for (int c = 0; c < 5; c++)
      for (int p = 9; p < 16; p++)
        access(0, {8'h00, 4'(c), 4'(p), 16'h0008}, 3'h0, 8'h00, c < 4 && (p < 12 || (p == 12 && c == 0)));
    $display("page map test done");
  endtask : t_page_map

  task automatic t_security;
    for (int p = 9; p < 13; p++)
      access(0, {12'h000, 4'(p), 16'h0010}, 3'h2, 8'h00, p == 9);
    access(1, 32'h001a_0008, 3'h2, 8'h00, 0);
    access(1, 32'h0019_0100, 3'h2, 8'h00, 1);
    $display("security test done");
  endtask : t_security

  task automatic t_err_layout;
    logic [15:0] offs [8] = '{16'h0000, 16'h0038, 16'h0040, 16'h0400, 16'h0800, 16'h0810, 16'h0818, 16'h0ff8};
    for (int i = 0; i < 8; i++)
      access(0, {12'h002, 4'ha, offs[i]}, 3'h0, 8'h00,
             offs[i] < 16'h0040 || (offs[i] >= 16'h0800 && offs[i] < 16'h0818) || offs[i] >= 16'h0e00);
    access(0, 32'h0109_0000, 3'h0, 8'h00, 0);
    $display("error layout test done");
  endtask : t_err_layout

  task automatic t_writes;
    access(1, 32'h003b_fff8, 3'h0, 8'h00, 1);
    access(1, 32'h001c_0000, 3'h0, 8'h00, 0);
    access(1, 32'h000e_0000, 3'h0, 8'h00, 0);
    $display("write test done");
  endtask : t_writes

  // bursts with a slow register set
  task automatic t_burst;
    delay <= 8'h14;
    access(0, 32'h0019_fff0, 3'h2, 8'h01, 1);
    access(0, 32'h000d_0000, 3'h0, 8'h03, 0);
    delay <= 8'h01;
    $display("burst test done");
  endtask : t_burst

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // the whole run needs a few hundred cycles; this is ample
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    end_of_test();
  end

  initial begin
    sys_rst_in = 1'b1;
    aw_in = '0;
    w_in = '0;
    ar_in = '0;
    b_ready_in = 1'b0;
    r_ready_in = 1'b0;
    delay = 8'h01;
    repeat (10) @(posedge clk_sys_in);
    @(negedge clk_sys_in) check({aw_ready_out, w_ready_out, ar_ready_out, b_out.valid, r_out.valid, req_out.valid}, 6'h00);
    @(posedge clk_sys_in) sys_rst_in <= 1'b0;
    t_page_map();
    t_security();
    t_err_layout();
    t_writes();
    t_burst();
    end_of_test();
  end
endmodule : utility_bus_page_decoder_tb
